// *** rtl/osctb_pkg.sv ***
/*
 * Constants, types and register map of the oscillator, time base and
 * watchdog enable control block.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package osctb_pkg;

    // Oscillator configuration option, fixed in the factory
    typedef enum logic [1:0] {
        OSC_EXT_XTAL     = 2'b00,
        OSC_EXT_RC       = 2'b01,
        OSC_RC_SLOW_XTAL = 2'b10,
        OSC_RC_ONLY      = 2'b11
    } osctb_osc_cfg_t;

    // Internal fast RC frequency option
    typedef enum logic [1:0] {
        RC_4MHZ  = 2'b00,
        RC_8MHZ  = 2'b01,
        RC_12MHZ = 2'b10
    } osctb_rc_freq_t;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;

    localparam logic [ADDR_W-1:0] ADDR_CTRL0  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_SYSCTL_ONE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;

    localparam logic [REG_W-1:0] CTRL0_RST = 8'h00;
    localparam logic [REG_W-1:0] SYSCTL_ONE_RST = 8'h8a;
    localparam logic [REG_W-1:0] CTRL0_MASK = 8'h0b;

    // Control zero fields
    localparam int C0_CLK_SEL = 0;
    localparam int C0_XTAL_LP = 1;
    localparam int C0_PWM_OUT = 3;

    // Control one fields
    localparam int C1_WDT_LSB = 0;
    localparam int C1_TB_LSB  = 4;
    localparam int C1_INT_LSB = 6;

    // Status fields
    localparam int ST_WDT_EN   = 0;
    localparam int ST_SLOW_SYS = 1;
    localparam int ST_FAST_RUN = 2;
    localparam int ST_XTAL_RUN = 3;
    localparam int ST_SRC_RUN  = 4;
    localparam int ST_PIN_A    = 5;
    localparam int ST_PIN_B    = 6;
    localparam int ST_SLEEP    = 7;

    localparam logic [3:0] WDT_OFF_CODE = 4'ha;
    localparam logic [3:0] WDT_ON_CODE  = 4'h5;
    localparam int         TB_BASE_EXP  = 10;

endpackage

// *** rtl/osctb_sync_if.sv ***
/*
 * Carrier for a synchronised oscillator input: its filtered level and a
 * one-cycle pulse on each accepted rising edge.
 * Assumes both ends run on the one system clock.
 */
`timescale 1ns/1ps

interface osctb_sync_if;
    logic level;
    logic rise;

    modport src (output level, output rise);
    modport dst (input  level, input  rise);
endinterface

// *** rtl/osctb_sync_edge.sv ***
/*
 * Three-stage synchroniser for an oscillator pin. A change counts once
 * the second and third stages agree; each accepted rise gives one pulse.
 * Assumes the pin toggles slower than half the system clock.
 */
`timescale 1ns/1ps

module osctb_sync_edge #(
    parameter logic INIT = 1'b0
) (
    input  wire logic   clk_i,   // System clock
    input  wire logic   rst_i,   // Synchronous reset, active high
    input  wire logic   pin_i,   // Asynchronous oscillator input
    osctb_sync_if.src   sync     // Filtered level and rise pulse
);

    logic ff1;
    logic ff2;
    logic ff3;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ff1 <= INIT;
            ff2 <= INIT;
            ff3 <= INIT;
        end
        else
        begin
            ff1 <= pin_i;
            ff2 <= ff1;
            ff3 <= ff2;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync.level <= INIT;
            sync.rise  <= 1'b0;
        end
        else
        begin
            if (ff2 == ff3)
            begin
                sync.level <= ff3;
            end
            sync.rise <= (ff2 == ff3) && ff3 && !sync.level;
        end
    end

endmodule // osctb_sync_edge

// *** rtl/osctb_ctrl.sv ***
/*
 * Oscillator selection, time base and watchdog enable control with a
 * classic Wishbone register slave.
 * Assumes the fast clock sources are modelled by clk_i itself and the
 * slow sources arrive as pins; factory options are static straps.
 */
// The Wishbone register port and the register addresses are this design's own decisions.
// What this block does
// - Period code picks 2^10..2^13 time base cycles
// - Watchdog off only for enable code 1010
// - Always-on option forces watchdog on, ignores code
// - Oscillators also clock watchdog and time base
// - Fast RC runs at 4, 8 or 12MHz
// - Fast RC option frees both shared pins
// - External RC uses pin one only, frees other
// - Slow crystal allowed only with fast RC
// - Low-power bit: 0 quick start, 1 low power
// - Power-on clears the slow crystal low-power bit
// - Slow crystal runs whatever the low-power bit
// - Sleep stops system clock, slow crystal keeps timers
// - Slow RC free-runs in sleep for watchdog
// - Option can disable the slow RC entirely
// - PWM output forces time base clock from system
// - Clock select: 0 fast RC, 1 slow crystal
`timescale 1ns/1ps

module osctb_ctrl
    import osctb_pkg::*;
#(
    parameter int TB_WIDTH = 13
) (
    input  wire logic                   clk_i,      // System clock
    input  wire logic                   rst_i,      // Power-on reset
    input  wire logic                   cyc_i,      // Wishbone cycle
    input  wire logic                   stb_i,      // Wishbone strobe
    input  wire logic                   we_i,       // Write enable
    input  wire logic [osctb_pkg::ADDR_W-1:0] adr_i, // Byte address
    input  wire logic [3:0]             sel_i,      // Byte selects
    input  wire logic [osctb_pkg::DATA_W-1:0] dat_i, // Write data
    output logic [osctb_pkg::DATA_W-1:0] dat_o,     // Read data
    output logic                        ack_o,      // Wishbone ack
    input  wire osctb_pkg::osctb_osc_cfg_t cfg_osc_i, // Osc option
    input  wire osctb_pkg::osctb_rc_freq_t cfg_rc_freq_i, // RC freq
    input  wire logic                   cfg_wdt_on_i,  // Wdt forced
    input  wire logic                   cfg_slow_rc_off_i, // Slow RC off
    input  wire logic                   sleep_i,    // Sleep request
    input  wire logic                   slow_xtal_pin_i, // Slow crystal
    input  wire logic                   slow_rc_pin_i, // Slow RC
    output logic                        sys_clk_en_o,  // System tick
    output logic                        timebase_clock_en_o, // Tick
    output logic                        timebase_event_o, // Period
    output logic                        watchdog_enable_o, // Wdt on
    output logic                        watchdog_clk_en_o, // Wdt tick
    output logic                        internal_fast_rc_run_o, // Run
    output osctb_pkg::osctb_rc_freq_t   internal_fast_rc_freq_o, // Freq
    output logic                        ext_fast_osc_run_o, // Ext fast
    output logic                        slow_crystal_osc_run_o, // Run
    output logic                        slow_crystal_low_power_o, // LP
    output logic                        internal_slow_rc_run_o, // Run
    output logic                        osc_shared_pin_a_gpio_o, // Free
    output logic                        osc_shared_pin_b_gpio_o, // Free
    output logic [1:0]                  ext_int_edge_o  // Edge type
);

    ////////////////////////////////////////////////////////////////////
    // Parameter check

    generate
        if (TB_WIDTH < TB_BASE_EXP + 3)
        begin : g_bad_width
            $error("TB_WIDTH too small for longest time base period");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Factory options, caught once after reset release

    osctb_osc_cfg_t   osc_cfg;
    osctb_rc_freq_t   rc_freq_cfg;
    logic             wdt_forced;
    logic             slow_rc_off;
    logic             straps_taken;

    // Straps are sampled once so a glitching option pin cannot
    // reconfigure the clock tree while the core is running
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            osc_cfg      <= OSC_RC_ONLY;
            rc_freq_cfg  <= RC_4MHZ;
            wdt_forced   <= 1'b1;
            slow_rc_off  <= 1'b0;
            straps_taken <= 1'b0;
        end
        else if (!straps_taken)
        begin
            osc_cfg      <= cfg_osc_i;
            rc_freq_cfg  <= cfg_rc_freq_i;
            wdt_forced   <= cfg_wdt_on_i;
            slow_rc_off  <= cfg_slow_rc_off_i;
            straps_taken <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Slow oscillator pins

    osctb_sync_if xtal_sync ();
    osctb_sync_if slowrc_sync ();

    osctb_sync_edge #(
        .INIT  (1'b0)
    ) u_xtal_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pin_i (slow_xtal_pin_i),
        .sync  (xtal_sync.src)
    );

    osctb_sync_edge #(
        .INIT  (1'b0)
    ) u_slowrc_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pin_i (slow_rc_pin_i),
        .sync  (slowrc_sync.src)
    );

    ////////////////////////////////////////////////////////////////////
    // Control registers

    logic [REG_W-1:0] ctrl0;
    logic [REG_W-1:0] system_control_one;
    logic             bus_req;
    logic             wr_low;

    assign bus_req = cyc_i && stb_i && !ack_o;
    // Writes land on the acknowledged edge, while the master still
    // holds address and data, so an abandoned request changes nothing
    assign wr_low  = cyc_i && stb_i && ack_o && we_i && sel_i[0];

    // Power-on clears the low-power bit so the crystal starts quickly
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl0 <= CTRL0_RST;
        end
        else if (wr_low && adr_i == ADDR_CTRL0)
        begin
            ctrl0 <= dat_i[REG_W-1:0] & CTRL0_MASK;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            system_control_one <= SYSCTL_ONE_RST;
        end
        else if (wr_low && adr_i == ADDR_SYSCTL_ONE)
        begin
            system_control_one <= dat_i[REG_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clock source selection

    logic       xtal_cfg;
    logic       slow_sys;
    logic       fast_run;
    logic       slow_rc_run;
    logic       sys_tick;
    logic       tb_tick;
    logic       wdt_tick;
    logic       wdt_en;
    logic [3:0] wdt_code;
    logic [1:0] tb_sel;

    assign wdt_code = system_control_one[C1_WDT_LSB +: 4];
    assign tb_sel   = system_control_one[C1_TB_LSB +: 2];

    // Slow crystal exists only beside the fast RC
    assign xtal_cfg = (osc_cfg == OSC_RC_SLOW_XTAL);
    // Clock select is honoured only in that pairing
    assign slow_sys = xtal_cfg && ctrl0[C0_CLK_SEL];
    assign fast_run = (osc_cfg == OSC_RC_ONLY || xtal_cfg)
                      && !slow_sys && !sleep_i;
    assign slow_rc_run = !slow_rc_off;

    // Fast sources are the system clock itself; sleep stops it
    assign sys_tick = !sleep_i
                      && (slow_sys ? xtal_sync.rise : 1'b1);

    // Without PWM the slow crystal keeps the timers going in sleep
    assign tb_tick = (ctrl0[C0_PWM_OUT] || !xtal_cfg) ? sys_tick
                     : xtal_sync.rise;

    // Slow RC ignores sleep so the watchdog stays alive
    assign wdt_tick = slow_rc_run ? slowrc_sync.rise
                      : sys_tick;

    assign wdt_en = wdt_forced
                    || (wdt_code != WDT_OFF_CODE);

    ////////////////////////////////////////////////////////////////////
    // Time base

    logic [TB_WIDTH-1:0] tb_count;
    logic [TB_WIDTH-1:0] tb_limit;
    logic                tb_done;

    // Period is 2^(10+sel) ticks of the time base clock
    assign tb_limit = TB_WIDTH'((1 << (TB_BASE_EXP + int'(tb_sel)))
                                - 1);
    assign tb_done  = tb_tick && (tb_count >= tb_limit);

    // The >= guards against a shorter period chosen mid-count
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tb_count <= '0;
        end
        else if (tb_done)
        begin
            tb_count <= '0;
        end
        else if (tb_tick)
        begin
            tb_count <= tb_count + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registered outputs

    // Tick pulses: registered so consumers see clean one-cycle enables
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sys_clk_en_o        <= 1'b0;
            timebase_clock_en_o <= 1'b0;
            timebase_event_o    <= 1'b0;
            watchdog_clk_en_o   <= 1'b0;
        end
        else
        begin
            sys_clk_en_o        <= sys_tick;
            timebase_clock_en_o <= tb_tick;
            timebase_event_o    <= tb_done;
            watchdog_clk_en_o   <= wdt_tick;
        end
    end

    // Oscillator run states and pin release
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            watchdog_enable_o       <= 1'b1;
            internal_fast_rc_run_o  <= 1'b0;
            internal_fast_rc_freq_o <= RC_4MHZ;
            ext_fast_osc_run_o      <= 1'b0;
            slow_crystal_osc_run_o  <= 1'b0;
            internal_slow_rc_run_o  <= 1'b0;
            osc_shared_pin_a_gpio_o <= 1'b0;
            osc_shared_pin_b_gpio_o <= 1'b0;
        end
        else
        begin
            watchdog_enable_o       <= wdt_en;
            internal_fast_rc_run_o  <= fast_run;
            internal_fast_rc_freq_o <= rc_freq_cfg;
            ext_fast_osc_run_o      <= (osc_cfg == OSC_EXT_XTAL
                                       || osc_cfg == OSC_EXT_RC)
                                       && !sleep_i;
            // Runs in sleep and in either power mode
            slow_crystal_osc_run_o  <= xtal_cfg;
            internal_slow_rc_run_o  <= slow_rc_run;
            osc_shared_pin_a_gpio_o <= (osc_cfg == OSC_RC_ONLY);
            osc_shared_pin_b_gpio_o <= (osc_cfg == OSC_RC_ONLY)
                                       || (osc_cfg == OSC_EXT_RC);
        end
    end

    // Register mirrors
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            slow_crystal_low_power_o <= 1'b0;
            ext_int_edge_o           <= 2'h0;
        end
        else
        begin
            slow_crystal_low_power_o <= ctrl0[C0_XTAL_LP];
            ext_int_edge_o <= system_control_one[C1_INT_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status and bus answer

    logic [REG_W-1:0] status;

    always_comb
    begin
        status              = '0;
        status[ST_WDT_EN]   = watchdog_enable_o;
        status[ST_SLOW_SYS] = slow_sys;
        status[ST_FAST_RUN] = internal_fast_rc_run_o;
        status[ST_XTAL_RUN] = slow_crystal_osc_run_o;
        status[ST_SRC_RUN]  = internal_slow_rc_run_o;
        status[ST_PIN_A]    = osc_shared_pin_a_gpio_o;
        status[ST_PIN_B]    = osc_shared_pin_b_gpio_o;
        status[ST_SLEEP]    = sleep_i;
    end

    // One wait state; unmapped reads return zero, writes are dropped
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end
        else
        begin
            ack_o <= bus_req;
            dat_o <= '0;
            if (bus_req && !we_i)
            begin
                case (adr_i)
                    ADDR_CTRL0:  dat_o <= DATA_W'(ctrl0);
                    ADDR_SYSCTL_ONE: dat_o <= DATA_W'(system_control_one);
                    ADDR_STATUS: dat_o <= DATA_W'(status);
                    default:     dat_o <= '0;
                endcase
            end
        end
    end

endmodule // osctb_ctrl

// *** verification/osctb_ctrl_asserts.sv ***
/*
 * Port-level checker for the oscillator, time base and watchdog control.
 * Assumes binding to osctb_ctrl with straps held steady after reset.
 */
`timescale 1ns/1ps

module osctb_ctrl_asserts
    import osctb_pkg::*;
#(
    parameter int TB_WIDTH = 13
) (
    input wire logic              clk_i,   // System clock
    input wire logic              rst_i,   // Synchronous reset
    input wire logic              cyc_i,   // Bus cycle
    input wire logic              stb_i,   // Bus strobe
    input wire logic              we_i,    // Write enable
    input wire logic [ADDR_W-1:0] adr_i,   // Byte address
    input wire logic [3:0]        sel_i,   // Byte selects
    input wire logic [DATA_W-1:0] dat_i,   // Write data
    input wire logic              ack_o,   // Bus ack
    input wire logic              cfg_wdt_on_i, // Watchdog forced
    input wire logic              sleep_i, // Sleep request
    input wire logic              sys_clk_en_o, // System tick
    input wire logic              timebase_clock_en_o, // Time base tick
    input wire logic              timebase_event_o, // Period event
    input wire logic              watchdog_enable_o, // Watchdog on
    input wire logic              ext_fast_osc_run_o, // External fast
    input wire logic              slow_crystal_osc_run_o, // Slow xtal
    input wire logic              slow_crystal_low_power_o, // Low power
    input wire logic              osc_shared_pin_a_gpio_o // Pin a free
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic req;
    logic wr1;
    assign req = cyc_i && stb_i && !ack_o;
    assign wr1 = req && we_i && adr_i == ADDR_SYSCTL_ONE && sel_i[0];

    ////////////////////////////////////////////////////////////////////////
    a_ack_one_cycle: assert property (req |=> ack_o ##1 !ack_o)
        else $error("ack is not a single pulse after a request");
    a_no_stray_ack: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without a request");
    a_wdt_code_on: assert property (
        wr1 && dat_i[3:0] != WDT_OFF_CODE |-> ##[1:3] watchdog_enable_o)
        else $error("watchdog not enabled by a non-off code");
    a_wdt_code_off: assert property (
        wr1 && dat_i[3:0] == WDT_OFF_CODE && !cfg_wdt_on_i
        |-> ##[1:3] !watchdog_enable_o)
        else $error("watchdog not disabled by the off code");
    a_wdt_forced_on: assert property (
        wr1 && cfg_wdt_on_i |=> watchdog_enable_o[*4])
        else $error("forced watchdog dropped");
    a_tb_event_tick: assert property (
        timebase_event_o |-> timebase_clock_en_o)
        else $error("time base event off its tick");
    a_tb_event_gap: assert property (
        timebase_event_o |=> !timebase_event_o[*8])
        else $error("time base events too close");
    a_sleep_stops: assert property (
        sleep_i[*3] |-> !sys_clk_en_o)
        else $error("system tick runs in sleep");
    a_pin_a_fast_rc: assert property (
        osc_shared_pin_a_gpio_o |-> !ext_fast_osc_run_o
        && !slow_crystal_osc_run_o)
        else $error("pin a freed while an oscillator uses it");
    a_xtal_with_rc: assert property (
        slow_crystal_osc_run_o |-> !ext_fast_osc_run_o)
        else $error("slow crystal with an external fast source");
    // Checked inside reset itself, so the usual disable is lifted
    a_lp_cleared: assert property (disable iff (1'b0)
        rst_i |=> !slow_crystal_low_power_o)
        else $error("low power bit not cleared by reset");

endmodule // osctb_ctrl_asserts

bind osctb_ctrl osctb_ctrl_asserts #(.TB_WIDTH(TB_WIDTH)) u_asserts (.*);

// *** verification/osctb_ctrl_tb.sv ***
/*
 * Self-checking bench for osctb_ctrl: registers over Wishbone, watchdog
 * code, time base periods, option straps and sleep.
 * Assumes slow pins are toggled here from the system clock.
 */
`timescale 1ns/1ps

module osctb_ctrl_tb;
    import osctb_pkg::*;

    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic sleep_i = 0, slow_xtal_pin_i = 0, slow_rc_pin_i = 0;
    logic cfg_wdt_on_i = 0, cfg_slow_rc_off_i = 0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0, div = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    osctb_osc_cfg_t   cfg_osc_i = OSC_RC_ONLY;
    osctb_rc_freq_t   cfg_rc_freq_i = RC_4MHZ, internal_fast_rc_freq_o;
    logic ack_o, sys_clk_en_o, timebase_clock_en_o, timebase_event_o;
    logic watchdog_enable_o, watchdog_clk_en_o, internal_fast_rc_run_o;
    logic ext_fast_osc_run_o, slow_crystal_osc_run_o;
    logic slow_crystal_low_power_o, internal_slow_rc_run_o;
    logic osc_shared_pin_a_gpio_o, osc_shared_pin_b_gpio_o;
    logic [1:0] ext_int_edge_o;
    int err_count = 0, total_checks = 0, n;

    osctb_ctrl #(.TB_WIDTH(13)) DUT (.*);

    initial forever #10 clk_i = ~clk_i;

    // Slow sources well under half the system rate
    always @(posedge clk_i)
    begin
        div <= div + 4'h1;
        if (div == 4'h0) slow_xtal_pin_i <= ~slow_xtal_pin_i;
        if (div[2:0] == 3'h3) slow_rc_pin_i <= ~slow_rc_pin_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w;
        adr_i <= a; dat_i <= d; sel_i <= 4'h1;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (ack_o !== 1'b1 && k < 50);
        chk("ack", 32'h1, {31'h0, ack_o});
        q = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    endtask

    task automatic wait_ev();
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (timebase_event_o !== 1'b1 && n < 20000);
    endtask

    task automatic do_reset(input osctb_osc_cfg_t o,
                            input osctb_rc_freq_t h,
                            input logic w, input logic l);
        @(posedge clk_i);
        rst_i <= 1'b1; cfg_osc_i <= o; cfg_rc_freq_i <= h;
        cfg_wdt_on_i <= w; cfg_slow_rc_off_i <= l;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (5) @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        wb(0, ADDR_CTRL0, 32'h0); chk("ctrl0", 32'h0, q);
        wb(0, ADDR_SYSCTL_ONE, 32'h0); chk("sysctl_one", 32'h8a, q);
        chk("wdt_en", 32'h0, watchdog_enable_o);
        chk("int_edge", 32'h2, ext_int_edge_o);
        wb(1, ADDR_CTRL0, 32'hff);
        wb(0, ADDR_CTRL0, 32'h0); chk("ctrl0", 32'h0b, q);
        chk("low_pwr", 32'h1, slow_crystal_low_power_o);
        wb(1, ADDR_STATUS, 32'h0);
        wb(0, ADDR_STATUS, 32'h0); chk("status", 32'h74, q);
        wb(0, 8'h0c, 32'h0); chk("unmapped", 32'h0, q);
        do_reset(OSC_RC_ONLY, RC_4MHZ, 1'b0, 1'b0);
        chk("low_pwr", 32'h0, slow_crystal_low_power_o);
        $display("regs test done");
    endtask

    task automatic t_wdt();
        logic [3:0] c [5] = '{4'h0, 4'h5, 4'ha, 4'hb, 4'hf};
        foreach (c[i])
        begin
            wb(1, ADDR_SYSCTL_ONE, {24'h0, 4'h8, c[i]});
            repeat (3) @(posedge clk_i);
            chk("wdt_en", c[i] != 4'ha, watchdog_enable_o);
        end
        do_reset(OSC_RC_ONLY, RC_4MHZ, 1'b1, 1'b0);
        wb(1, ADDR_SYSCTL_ONE, 32'h8a);
        repeat (3) @(posedge clk_i);
        chk("wdt_forced", 32'h1, watchdog_enable_o);
        $display("watchdog test done");
    endtask

    task automatic t_tb();
        for (int s = 0; s < 4; s++)
        begin
            wb(1, ADDR_SYSCTL_ONE, {24'h0, 2'b10, s[1:0], 4'h5});
            wait_ev();
            wait_ev();
            chk("period", 32'h1 << (10 + s), n);
        end
        $display("time base test done");
    endtask

    task automatic t_opts();
        int w;
        int t;
        for (int o = 0; o < 4; o++)
        begin
            do_reset(osctb_osc_cfg_t'(o), osctb_rc_freq_t'(o % 3),
                     1'b0, o == 0);
            chk("pin_a", o == 3, osc_shared_pin_a_gpio_o);
            chk("pin_b", o == 3 || o == 1, osc_shared_pin_b_gpio_o);
            chk("xtal", o == 2, slow_crystal_osc_run_o);
            chk("ext_fast", o < 2, ext_fast_osc_run_o);
            chk("rc_run", o >= 2, internal_fast_rc_run_o);
            chk("rc_freq", o % 3, internal_fast_rc_freq_o);
            chk("internal_slow_rc", o != 0, internal_slow_rc_run_o);
            if (o == 2)
            begin
                sleep_i <= 1'b1;
                repeat (4) @(posedge clk_i);
                chk("sys_tick", 32'h0, sys_clk_en_o);
                chk("xtal_slp", 32'h1, slow_crystal_osc_run_o);
                chk("internal_slow_rc_slp", 32'h1, internal_slow_rc_run_o);
                w = 0;
                t = 0;
                repeat (48)
                begin
                    @(posedge clk_i);
                    w += watchdog_clk_en_o;
                    t += timebase_clock_en_o;
                end
                chk("wdt_tick_slp", 32'h1, w >= 2);
                chk("tb_tick_slp", 32'h1, t >= 1);
                sleep_i <= 1'b0;
                wb(1, ADDR_CTRL0, 32'h01);
                repeat (3) @(posedge clk_i);
                chk("rc_stop", 32'h0, internal_fast_rc_run_o);
                wb(1, ADDR_CTRL0, 32'h08);
                wait_ev();
                wait_ev();
                chk("pwm_period", 32'd1024, n);
            end
        end
        $display("options test done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        do_reset(OSC_RC_ONLY, RC_4MHZ, 1'b0, 1'b0);
        t_regs();
        t_wdt();
        t_tb();
        t_opts();
        print_verdict();
    end

    // Run needs under 40k cycles; this cuts a hang at 90k cycles
    initial
    begin
        #1_800_000;
        err_count++;
        print_verdict();
    end

endmodule // osctb_ctrl_tb
